/* ddr2_fe_pkg.sv */
package ddr2_fe_pkg;

    // -------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------
    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int DQ_W = 16;
    localparam int SYNC_STAGES = 2;

    // -------------------------------------------------------------------
    // command codes {ras_n, cas_n, we_n}, valid only with select low
    // -------------------------------------------------------------------
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_REFRESH = 3'h1;

    // -------------------------------------------------------------------
    // values after reset, and the per-width data termination masks
    // -------------------------------------------------------------------
    // high, so leaving reset never looks like a power-down entry
    localparam logic RST_CKE = 1'b1;
    localparam logic RST_CS_N = 1'b1;
    localparam logic RST_ODT = 1'b0;
    localparam logic [DQ_W-1:0] RST_TERM_DQ = 16'h0000;
    localparam logic [DQ_W-1:0] DQ_MASK_X4 = 16'h000F;
    localparam logic [DQ_W-1:0] DQ_MASK_X8 = 16'h00FF;
    localparam logic [DQ_W-1:0] DQ_MASK_X16 = 16'hFFFF;

    typedef enum logic [1:0] {
        WIDTH_X4,
        WIDTH_X8,
        WIDTH_X16
    } width_e;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_PD_PRECHARGE,
        PWR_PD_ACTIVE,
        PWR_SELF_REFRESH
    } pwr_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } cmd_s;

    typedef struct packed {
        logic ck;
        logic cke;
        logic odt;
        logic cmd_addr;
        logic data;
    } bufen_s;

    typedef struct packed {
        logic [DQ_W-1:0] dq;
        logic dqs_lo;
        logic dqs_hi;
        logic rdqs;
        logic dm_lo;
        logic dm_hi;
    } term_s;

    localparam cmd_s RST_CMD = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                 we_n: 1'b1, ba: 3'h0, addr: 14'h0000};
    localparam bufen_s RST_BUFEN = '{ck: 1'b1, cke: 1'b1, odt: 1'b1,
                                     cmd_addr: 1'b1, data: 1'b1};

endpackage

/* level_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module level_sync #(
    parameter int STAGES = 2,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);

    logic [STAGES-1:0] chain_r;
    logic [STAGES-1:0] chain_nxt;

    always_comb begin
        chain_nxt = {chain_r[STAGES-2:0], d};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chain_r <= {STAGES{RST_VAL}};
        end else begin
            chain_r <= chain_nxt;
        end
    end

    assign q = chain_r[STAGES-1];

endmodule

`default_nettype wire

/* ddr2_control_input_front_end.sv */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - address and control inputs captured on the rising clock edge
// - read data presented for both clock crossings, rise then fall
// - clock enable high runs clocks, buffers, drivers; low stops clocks, drivers, command and data buffers
// - enable low: precharge or active power-down, or self refresh
// - power-down entry, exit and self-refresh entry use sampled enable
// - self-refresh exit from clock enable level via synchroniser
// - power-down keeps only clock, termination and enable buffers on
// - self refresh keeps only the clock enable receiver on
// - commands ignored whenever chip select is sampled high
// - chip select is a command bit; controller uses it for rank pick
// - termination input sampled high outside self refresh turns internal termination on
// - narrow widths terminate data, both strobe pairs and data mask
// - sixteen-bit width terminates all data, both strobes, both masks
// - termination input ignored while termination disabled in config
// - command decoded from row, column, write strobes and chip select
module ddr2_control_input_front_end #(
    parameter int DQW = ddr2_fe_pkg::DQ_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cke_pin,
    input wire ddr2_fe_pkg::cmd_s cmd_pin,
    input wire logic odt_pin,
    input wire ddr2_fe_pkg::width_e width_cfg,
    input wire logic odt_allow_cfg,
    input wire logic any_bank_open,
    input wire logic [DQW-1:0] rd_rise,
    input wire logic [DQW-1:0] rd_fall,
    input wire logic rd_valid,
    output ddr2_fe_pkg::cmd_s cmd_out,
    output logic cmd_valid,
    output ddr2_fe_pkg::pwr_e pwr_state,
    output logic clk_run,
    output ddr2_fe_pkg::bufen_s buf_en,
    output logic drv_en,
    output ddr2_fe_pkg::term_s term_en,
    output logic [DQW-1:0] dq_rise_out,
    output logic [DQW-1:0] dq_fall_out,
    output logic dq_out_valid
);
    import ddr2_fe_pkg::*;

    // -------------------------------------------------------------------
    // clock enable capture
    // -------------------------------------------------------------------
    // only one clock exists here, so the asynchronous exit path still
    // costs two cycles of latency through the synchroniser
    logic cke_sync;

    level_sync #(
        .STAGES(SYNC_STAGES),
        .RST_VAL(RST_CKE)
    ) u_cke_sync (
        .clk(clk),
        .rst(rst),
        .d(cke_pin),
        .q(cke_sync)
    );

    logic cke_r;
    logic cke_nxt;
    cmd_s cap_r;
    cmd_s cap_nxt;
    logic odt_r;
    logic odt_nxt;

    always_comb begin
        cke_nxt = cke_pin;
        cap_nxt = buf_en.cmd_addr ? cmd_pin : RST_CMD;
        odt_nxt = buf_en.odt ? odt_pin : RST_ODT;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cke_r <= RST_CKE;
            cap_r <= RST_CMD;
            odt_r <= RST_ODT;
        end else begin
            cke_r <= cke_nxt;
            cap_r <= cap_nxt;
            odt_r <= odt_nxt;
        end
    end

    // -------------------------------------------------------------------
    // command masking and decode
    // -------------------------------------------------------------------
    logic selected;
    logic [2:0] op_code;
    logic is_refresh;

    always_comb begin
        selected = ~cap_r.cs_n;
        op_code = {cap_r.ras_n, cap_r.cas_n, cap_r.we_n};
        is_refresh = selected && (op_code == CMD_REFRESH);
    end

    pwr_e pwr_r;
    pwr_e pwr_nxt;
    cmd_s cmd_r;
    cmd_s cmd_nxt;
    logic cmd_valid_r;
    logic cmd_valid_nxt;

    always_comb begin
        cmd_nxt = cmd_r;
        cmd_valid_nxt = 1'b0;
        if (selected && op_code != CMD_NOP && cke_r &&
            pwr_r == PWR_ACTIVE) begin
            cmd_nxt = cap_r;
            cmd_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r <= RST_CMD;
            cmd_valid_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            cmd_valid_r <= cmd_valid_nxt;
        end
    end

    // -------------------------------------------------------------------
    // power state
    // -------------------------------------------------------------------
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_ACTIVE: begin
                if (!cke_r) begin
                    if (is_refresh) begin
                        pwr_nxt = PWR_SELF_REFRESH;
                    end else if (any_bank_open) begin
                        pwr_nxt = PWR_PD_ACTIVE;
                    end else begin
                        pwr_nxt = PWR_PD_PRECHARGE;
                    end
                end
            end
            PWR_PD_PRECHARGE, PWR_PD_ACTIVE: begin
                if (cke_r) begin
                    pwr_nxt = PWR_ACTIVE;
                end
            end
            PWR_SELF_REFRESH: begin
                if (cke_sync) begin
                    pwr_nxt = PWR_ACTIVE;
                end
            end
            default: begin
                pwr_nxt = PWR_ACTIVE;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // buffer gating, drivers and termination
    // -------------------------------------------------------------------
    bufen_s buf_r;
    bufen_s buf_nxt;
    logic run_r;
    logic run_nxt;
    term_s term_r;
    term_s term_nxt;
    logic term_on;

    always_comb begin
        buf_nxt = RST_BUFEN;
        run_nxt = 1'b1;
        case (pwr_nxt)
            PWR_PD_PRECHARGE, PWR_PD_ACTIVE: begin
                buf_nxt.cmd_addr = 1'b0;
                buf_nxt.data = 1'b0;
                run_nxt = 1'b0;
            end
            PWR_SELF_REFRESH: begin
                buf_nxt = '{ck: 1'b0, cke: 1'b1, odt: 1'b0,
                            cmd_addr: 1'b0, data: 1'b0};
                run_nxt = 1'b0;
            end
            default: begin
                buf_nxt = RST_BUFEN;
            end
        endcase
    end

    always_comb begin
        term_on = odt_r && odt_allow_cfg;
        term_nxt = '{dq: RST_TERM_DQ, dqs_lo: 1'b0, dqs_hi: 1'b0,
                     rdqs: 1'b0, dm_lo: 1'b0, dm_hi: 1'b0};
        if (term_on) begin
            case (width_cfg)
                WIDTH_X16: begin
                    term_nxt.dq = DQ_MASK_X16;
                    term_nxt.dqs_lo = 1'b1;
                    term_nxt.dqs_hi = 1'b1;
                    term_nxt.dm_lo = 1'b1;
                    term_nxt.dm_hi = 1'b1;
                end
                WIDTH_X8: begin
                    term_nxt.dq = DQ_MASK_X8;
                    term_nxt.dqs_lo = 1'b1;
                    term_nxt.rdqs = 1'b1;
                    term_nxt.dm_lo = 1'b1;
                end
                default: begin
                    term_nxt.dq = DQ_MASK_X4;
                    term_nxt.dqs_lo = 1'b1;
                    term_nxt.rdqs = 1'b1;
                    term_nxt.dm_lo = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_r <= PWR_ACTIVE;
            buf_r <= RST_BUFEN;
            run_r <= 1'b1;
            term_r <= '{dq: RST_TERM_DQ, dqs_lo: 1'b0, dqs_hi: 1'b0,
                        rdqs: 1'b0, dm_lo: 1'b0, dm_hi: 1'b0};
        end else begin
            pwr_r <= pwr_nxt;
            buf_r <= buf_nxt;
            run_r <= run_nxt;
            term_r <= term_nxt;
        end
    end

    // -------------------------------------------------------------------
    // read data output pair
    // -------------------------------------------------------------------
    // drivers follow the running clocks so a read cannot leak out in a
    // low-power state
    logic [DQW-1:0] rise_r;
    logic [DQW-1:0] rise_nxt;
    logic [DQW-1:0] fall_r;
    logic [DQW-1:0] fall_nxt;
    logic outv_r;
    logic outv_nxt;

    always_comb begin
        outv_nxt = rd_valid && run_nxt;
        rise_nxt = outv_nxt ? rd_rise : rise_r;
        fall_nxt = outv_nxt ? rd_fall : fall_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rise_r <= '0;
            fall_r <= '0;
            outv_r <= 1'b0;
        end else begin
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            outv_r <= outv_nxt;
        end
    end

    assign cmd_out = cmd_r;
    assign cmd_valid = cmd_valid_r;
    assign pwr_state = pwr_r;
    assign clk_run = run_r;
    assign buf_en = buf_r;
    assign drv_en = run_r;
    assign term_en = term_r;
    assign dq_rise_out = rise_r;
    assign dq_fall_out = fall_r;
    assign dq_out_valid = outv_r;

endmodule

`default_nettype wire

/* ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------
// controller side of the command pins
// -------------------------------------------
module ctl_model (
    input wire logic clk,
    output var logic cke_pin,
    output var ddr2_fe_pkg::cmd_s cmd_pin,
    output var logic odt_pin
);
    import ddr2_fe_pkg::*;
    cmd_s nxt;
    logic hold = 1'h0;
    logic cke_v = 1'h1;
    logic odt_v = 1'h0;
    initial begin
        cke_pin = 1'h1;
        cmd_pin = RST_CMD;
        odt_pin = 1'h0;
    end
    // falling edge only, so the device samples settled pins
    always @(negedge clk) begin
        cke_pin <= cke_v;
        odt_pin <= odt_v;
        // deselected: other pins wander, never hold the last value
        cmd_pin <= hold ? nxt : cmd_s'({1'h1, 20'($urandom)});
    end
    task automatic issue(input cmd_s c);
        nxt = c;
        hold = 1'h1;
        @(posedge clk);
        hold = 1'h0;
    endtask
endmodule
`default_nettype wire

/* fe_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module fe_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cke_pin,
    input wire ddr2_fe_pkg::cmd_s cmd_pin,
    input wire logic odt_pin,
    input wire ddr2_fe_pkg::width_e width_cfg,
    input wire logic odt_allow_cfg,
    input wire logic any_bank_open,
    input wire ddr2_fe_pkg::cmd_s cmd_out,
    input wire logic cmd_valid,
    input wire ddr2_fe_pkg::pwr_e pwr_state,
    input wire logic clk_run,
    input wire ddr2_fe_pkg::bufen_s buf_en,
    input wire logic drv_en,
    input wire ddr2_fe_pkg::term_s term_en
);
    import ddr2_fe_pkg::*;
    logic [1:0] up_r;
    logic odt_r;
    term_s exp_r;
    logic ok;
    logic pd;
    function automatic term_s tf(input logic on, input width_e w);
        tf = '0;
        if (on)
            tf = (w == WIDTH_X16) ? {16'hFFFF, 5'h1B} :
                {(w == WIDTH_X8) ? 16'h00FF : 16'h000F, 5'h16};
    endfunction
    // reset leaves the sampled enable stale, so wait a few edges
    always_ff @(posedge clk) begin
        up_r <= rst ? 2'h0 : up_r + {1'h0, up_r != 2'h3};
        odt_r <= odt_pin;
        exp_r <= tf(odt_r && odt_allow_cfg, width_cfg);
    end
    assign ok = up_r == 2'h3;
    assign pd = pwr_state inside {PWR_PD_PRECHARGE, PWR_PD_ACTIVE};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_mask_ignored: assert property (
        ok && buf_en.cmd_addr && cmd_pin.cs_n |-> ##2 !cmd_valid)
        else $error("masked command accepted");
    a_cmd_taken: assert property (
        ok && !cmd_pin.cs_n && {cmd_pin.ras_n, cmd_pin.cas_n,
        cmd_pin.we_n} != CMD_NOP && cke_pin && $past(cke_pin)
        && pwr_state == PWR_ACTIVE
        |-> ##2 cmd_valid && cmd_out == $past(cmd_pin, 2))
        else $error("command not taken");
    a_pd_entry: assert property (
        ok && pwr_state == PWR_ACTIVE && $past(cke_pin) && !cke_pin
        && cmd_pin.cs_n |-> ##2 pwr_state ==
        ($past(any_bank_open) ? PWR_PD_ACTIVE : PWR_PD_PRECHARGE))
        else $error("wrong power-down entry");
    a_reset_active: assert property (
        $fell(rst) && cke_pin
        |-> ##1 pwr_state == PWR_ACTIVE ##1 pwr_state == PWR_ACTIVE)
        else $error("power state left active after reset");
    a_sr_entry: assert property (
        ok && pwr_state == PWR_ACTIVE && $past(cke_pin) && !cke_pin
        && !cmd_pin.cs_n && {cmd_pin.ras_n, cmd_pin.cas_n,
        cmd_pin.we_n} == CMD_REFRESH
        |-> ##2 pwr_state == PWR_SELF_REFRESH)
        else $error("no self refresh entry");
    a_pd_exit: assert property (
        ok && pd && cke_pin |-> ##2 pwr_state == PWR_ACTIVE)
        else $error("late power-down exit");
    a_sr_exit: assert property (
        ok && pwr_state == PWR_SELF_REFRESH && cke_pin
        |-> ##[1:4] pwr_state == PWR_ACTIVE)
        else $error("late self refresh exit");
    a_pd_buffers: assert property (
        pd |-> buf_en == 5'h1C && !clk_run && !drv_en)
        else $error("power-down buffers wrong");
    a_sr_buffers: assert property (
        pwr_state == PWR_SELF_REFRESH
        |-> buf_en == 5'h08 && !clk_run && !drv_en)
        else $error("self refresh buffers wrong");
    a_odt_term: assert property (
        ok && $past(buf_en.odt, 2) |-> term_en == exp_r)
        else $error("termination wrong");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin \
    checks_done++; \
    if ((s) !== (e)) begin \
        fails++; \
        $display("MISMATCH %s exp %0h got %0h", n, e, s); \
    end \
end
module tb_top;
    import ddr2_fe_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cke_pin;
    cmd_s cmd_pin;
    logic odt_pin;
    width_e width_cfg = WIDTH_X16;
    logic odt_allow_cfg = 1'h1;
    logic any_bank_open = 1'h0;
    logic [15:0] rd_rise = 16'h0000;
    logic [15:0] rd_fall = 16'h0000;
    logic rd_valid = 1'h0;
    cmd_s cmd_out;
    logic cmd_valid;
    pwr_e pwr_state;
    logic clk_run;
    bufen_s buf_en;
    logic drv_en;
    term_s term_en;
    logic [15:0] dq_rise_out;
    logic [15:0] dq_fall_out;
    logic dq_out_valid;
    int fails = 0;
    int checks_done = 0;
    cmd_s cq[$];
    logic [31:0] rq[$];
    cmd_s c;
    cmd_s m;
    logic [31:0] r;
    term_s t;
    pwr_e pe;
    ctl_model u_ctl (.clk(clk), .cke_pin(cke_pin), .cmd_pin(cmd_pin),
        .odt_pin(odt_pin));
    ddr2_control_input_front_end u_dut (
        .clk(clk),
        .rst(rst),
        .cke_pin(cke_pin),
        .cmd_pin(cmd_pin),
        .odt_pin(odt_pin),
        .width_cfg(width_cfg),
        .odt_allow_cfg(odt_allow_cfg),
        .any_bank_open(any_bank_open),
        .rd_rise(rd_rise),
        .rd_fall(rd_fall),
        .rd_valid(rd_valid),
        .cmd_out(cmd_out),
        .cmd_valid(cmd_valid),
        .pwr_state(pwr_state),
        .clk_run(clk_run),
        .buf_en(buf_en),
        .drv_en(drv_en),
        .term_en(term_en),
        .dq_rise_out(dq_rise_out),
        .dq_fall_out(dq_fall_out),
        .dq_out_valid(dq_out_valid)
    );
    initial forever #12.5 clk = ~clk;
    // -------------------------------------------
    // result watcher
    // -------------------------------------------
    always @(posedge clk) begin
        #1;
        if (cmd_valid !== 1'h0) begin
            m = cq.size() ? cq.pop_front() : ~cmd_out;
            `CHK("cmd_out", m, cmd_out)
        end
        if (dq_out_valid !== 1'h0) begin
            r = rq.size() ? rq.pop_front() : ~{dq_rise_out, dq_fall_out};
            `CHK("rd_pair", r, {dq_rise_out, dq_fall_out})
        end
    end
    task automatic rd_beat(input logic exp);
        @(negedge clk);
        rd_valid = 1'h1;
        rd_rise = 16'($urandom);
        rd_fall = 16'($urandom);
        if (exp)
            rq.push_back({rd_rise, rd_fall});
    endtask
    task automatic go_low(input logic sel_n);
        @(posedge clk);
        c = RST_CMD;
        c.cs_n = sel_n;
        {c.ras_n, c.cas_n, c.we_n} = CMD_REFRESH;
        u_ctl.cke_v = 1'h0;
        u_ctl.issue(c);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #50us;
        fails++;
        end_sim();
    end
    initial begin
        void'($urandom(13075));
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            c = cmd_s'(21'($urandom));
            if (!c.cs_n && {c.ras_n, c.cas_n, c.we_n} != CMD_NOP)
                cq.push_back(c);
            u_ctl.issue(c);
        end
        for (int i = 0; i < 8; i++)
            rd_beat(1'h1);
        @(negedge clk);
        rd_valid = 1'h0;
        // masked refresh must give power-down, never self refresh
        for (int b = 0; b < 2; b++) begin
            @(negedge clk);
            any_bank_open = b[0];
            go_low(1'h1);
            pe = b ? PWR_PD_ACTIVE : PWR_PD_PRECHARGE;
            `CHK("pd", pe, pwr_state)
            `CHK("pd_buf", 5'h1C, buf_en)
            rd_beat(1'h0);
            @(negedge clk);
            rd_valid = 1'h0;
            @(posedge clk);
            u_ctl.cke_v = 1'h1;
            repeat (3) @(posedge clk);
            #1;
            `CHK("pd_exit", PWR_ACTIVE, pwr_state)
        end
        go_low(1'h0);
        `CHK("sr", PWR_SELF_REFRESH, pwr_state)
        `CHK("sr_buf", 5'h08, buf_en)
        `CHK("sr_run", 1'h0, clk_run | drv_en)
        u_ctl.cke_v = 1'h1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("sr_exit", PWR_ACTIVE, pwr_state)
        `CHK("run", 2'h3, {clk_run, drv_en})
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            u_ctl.odt_v = k >= 6;
            @(negedge clk);
            width_cfg = width_e'(k % 3);
            odt_allow_cfg = (k / 3) % 2;
            repeat (3) @(posedge clk);
            #1;
            t = '0;
            if (odt_allow_cfg && u_ctl.odt_v)
                t = (k % 3 == 2) ? {16'hFFFF, 5'h1B} :
                    {(k % 3 == 1) ? 16'h00FF : 16'h000F, 5'h16};
            `CHK("term", t, term_en)
        end
        repeat (4) @(posedge clk);
        #2;
        `CHK("left", 0, cq.size() + rq.size())
        end_sim();
    end
endmodule
bind ddr2_control_input_front_end fe_asserts u_chk (.*);
`default_nettype wire
